// >>> dv/abw_sequencer_checker.sv
// Checker for the write and locked-cycle bus sequencer.
// Assumes the sequencer's port names; bound at the foot.
`timescale 1ns/1ps
module abw_sequencer_checker #(
    parameter bit REDUCED = 1'b0
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [31:0] addr,
    input wire logic [2:0] space_code,
    input wire logic read_write,
    input wire logic addr_strobe_n,
    input wire logic data_strobe_n,
    input wire logic data_buffer_enable_n,
    input wire logic ext_cycle_start_n,
    input wire logic operand_cycle_start_n,
    input wire logic locked_cycle_n,
    input wire logic [31:0] data_out,
    input wire logic data_oe,
    input wire logic xfer_ack_hi_n,
    input wire logic xfer_ack_lo_n,
    input wire logic bus_grant_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Cycle start strobes and what follows them
    a_start_then_as: assert property ($fell(ext_cycle_start_n) |=>
        !addr_strobe_n && ext_cycle_start_n && operand_cycle_start_n) else $error("S1 strobes wrong");
    a_op_with_start: assert property (!operand_cycle_start_n |-> !ext_cycle_start_n)
        else $error("operand start without cycle start");
    a_write_phases: assert property (!ext_cycle_start_n && !read_write |=>
        (REDUCED || !data_buffer_enable_n) ##1 data_oe ##1 !data_strobe_n) else $error("write phases wrong");
    // Acknowledge sampled at the end of S2
    a_ack_no_wait: assert property ((!ext_cycle_start_n ##2 !(xfer_ack_hi_n && xfer_ack_lo_n)) |=>
        !addr_strobe_n ##1 !addr_strobe_n ##1 addr_strobe_n) else $error("early ack did not end cycle");
    a_ack_waits: assert property ((!ext_cycle_start_n ##2 (xfer_ack_hi_n && xfer_ack_lo_n)) |=>
        !addr_strobe_n [*3]) else $error("missing wait states");
    a_s5_hold: assert property ($rose(addr_strobe_n) && !read_write |->
        $stable(addr) && $stable(data_out) && $stable(space_code) && $stable(data_buffer_enable_n)
        && data_oe && data_strobe_n) else $error("S5 hold broken");
    // Lock and grant
    a_lock_from_read: assert property ($fell(locked_cycle_n) |-> (REDUCED || !ext_cycle_start_n) && read_write)
        else $error("lock not at read S0");
    a_lock_no_grant: assert property (!locked_cycle_n |-> bus_grant_n)
        else $error("grant during lock");
    a_grant_idle: assert property (!bus_grant_n |-> addr_strobe_n && data_strobe_n && locked_cycle_n)
        else $error("grant while bus busy");
    c_locked_write: cover property (!locked_cycle_n && !read_write);
    c_waits: cover property (!ext_cycle_start_n ##2 xfer_ack_hi_n ##3 !xfer_ack_hi_n);
    c_grant: cover property (!bus_grant_n);
endmodule

bind abw_sequencer abw_sequencer_checker #(.REDUCED(REDUCED)) u_chk (.*);

// >>> dv/abw_slave_model.sv
// Slave memory on the asynchronous bus: 32-bit port, 64 bytes.
// Assumes one bus state per clock; waits delays the acknowledge.
`timescale 1ns/1ps
module abw_slave_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [3:0] waits,
    input wire logic [31:0] addr,
    input wire logic read_write,
    input wire logic xfer_size_hi,
    input wire logic xfer_size_lo,
    input wire logic addr_strobe_n,
    input wire logic data_strobe_n,
    input wire logic [31:0] data_out,
    output logic xfer_ack_hi_n,
    output logic xfer_ack_lo_n,
    output logic [31:0] data_in
);
    logic [7:0] mem [0:63];
    logic [3:0] cnt;
    logic [2:0] nb;
    logic [5:0] base;
    // Byte count and word base of the current cycle
    assign nb = ({xfer_size_hi, xfer_size_lo} == 2'h0) ? 3'h4 : {1'b0, xfer_size_hi, xfer_size_lo};
    assign base = {addr[5:2], 2'h0};
    assign xfer_ack_lo_n = xfer_ack_hi_n;
    initial for (int i = 0; i < 64; i++) mem[i] = 8'h00;
    // Acknowledge after the wait count, drop it one edge after the strobe negates
    always @(posedge clock) begin
        if (!reset_n || addr_strobe_n) begin
            xfer_ack_hi_n <= 1'b1;
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
            if (cnt == waits) xfer_ack_hi_n <= 1'b0;
        end
    end
    // Latch selected lanes; return read data, else a toggling pattern
    always @(posedge clock) begin
        if (!reset_n) data_in <= 32'h0;
        else if (!data_strobe_n && read_write) data_in <= {mem[base], mem[base+1], mem[base+2], mem[base+3]};
        else data_in <= ~data_in;
        if (reset_n && !data_strobe_n && !read_write) begin
            for (int k = 0; k < 4; k++) begin
                if (k >= addr[1:0] && k < addr[1:0] + nb) mem[base+k] <= data_out[31-8*k -: 8];
            end
        end
    end
endmodule

// >>> dv/tb_top.sv
// Testbench for the bus write and locked read-modify-write sequencer.
// Assumes the slave model and checker are compiled before it.
`timescale 1ns/1ps
module tb_top;
    import abw_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic bus_request_n = 1'b1;
    logic as_q = 1'b1;
    logic [3:0] waits = 4'h0;
    logic req_ready, rsp_valid, read_write, xfer_size_hi, xfer_size_lo, addr_strobe_n, data_strobe_n;
    logic data_buffer_enable_n, ext_cycle_start_n, operand_cycle_start_n, locked_cycle_n, data_oe;
    logic xfer_ack_hi_n, xfer_ack_lo_n, bus_grant_n;
    logic [2:0] space_code;
    logic [31:0] addr, data_out, data_in;
    logic [31:0] r_addr;
    logic r_start_n, r_op_start_n, r_buf_en_n, r_seen = 1'b0;
    abw_req_type req_data = '0;
    abw_rsp_type rsp_data, rsp_q;
    int errors = 0, checks = 0, n_cyc = 0, n_wr = 0, len = 0, last_len = 0;
    abw_sequencer DUT (.*);
    abw_slave_model u_slave (.*);
    // Reduced variant shadows the main one on the same bus inputs
    abw_sequencer #(.REDUCED(1'b1)) DUT_R (.clock, .reset_n, .req_valid, .req_ready(), .req_data, .rsp_valid(),
        .rsp_data(), .addr(r_addr), .space_code(), .read_write(), .xfer_size_hi(), .xfer_size_lo(),
        .addr_strobe_n(), .data_strobe_n(), .data_buffer_enable_n(r_buf_en_n), .ext_cycle_start_n(r_start_n),
        .operand_cycle_start_n(r_op_start_n), .locked_cycle_n(), .data_out(), .data_oe(), .data_in,
        .xfer_ack_hi_n, .xfer_ack_lo_n, .bus_request_n, .bus_grant_n());
    always #50 clock = ~clock;
    // Count cycle starts, measure S1 to S5, keep the last response
    always @(posedge clock) begin
        if (ext_cycle_start_n === 1'b0) begin
            n_cyc <= n_cyc + 1;
            n_wr <= n_wr + (read_write === 1'b0);
            len <= 0;
        end else len <= len + 1;
        if (addr_strobe_n && !as_q) last_len <= len;
        as_q <= addr_strobe_n;
        if (rsp_valid === 1'b1) rsp_q <= rsp_data;
        if (reset_n === 1'b1 && {r_start_n, r_op_start_n, r_buf_en_n} !== 3'h7) r_seen <= 1'b1;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Offer one request, wait for its bus cycles, then count them
    task automatic run(input abw_op_type op, input logic [31:0] a, a2, input logic [1:0] sz,
                       input logic [31:0] wd, wd2, c, c2, input int ec, ew);
        int t;
        n_cyc = 0;
        n_wr = 0;
        req_data <= '{op: op, addr: a, addr2: a2, space: 3'h5, size: sz, wdata: wd, wdata2: wd2, cmp: c, cmp2: c2};
        req_valid <= 1'b1;
        t = 0;
        do @(posedge clock); while (req_ready !== 1'b1 && ++t < 50);
        req_valid <= 1'b0;
        do @(posedge clock); while (!(n_cyc >= ec && addr_strobe_n === 1'b1 && locked_cycle_n === 1'b1) && ++t < 300);
        if (t >= 300) begin
            errors++;
            tally_and_finish();
        end
        repeat (12) @(posedge clock);
        chk("bus cycles", n_cyc, ec);
        chk("write cycles", n_wr, ew);
    endtask
    task automatic t_write_waits;
        int wt[3] = '{0, 1, 4};
        int el[3] = '{4, 6, 8};
        for (int i = 0; i < 3; i++) begin
            waits <= wt[i][3:0];
            run(ABW_OP_WRITE, 32'h7F000020, 32'h0, 2'h0, 32'hC0DE0000 | i, 32'h0, 32'h0, 32'h0, 1, 1);
            chk("cycle length", last_len, el[i]);
            chk("long", {u_slave.mem[32], u_slave.mem[33], u_slave.mem[34], u_slave.mem[35]}, 32'hC0DE0000 | i);
            chk("full addr", addr, 32'h7F000020);
            chk("reduced addr", r_addr, 32'h00000020);
            chk("space", space_code, 32'h5);
        end
        waits <= 4'h0;
    endtask
    task automatic t_misaligned;
        run(ABW_OP_WRITE, 32'h3, 32'h0, 2'h1, 32'hAB, 32'h0, 32'h0, 32'h0, 1, 1);
        chk("byte", {24'h0, u_slave.mem[3]}, 32'hAB);
        run(ABW_OP_WRITE, 32'h6, 32'h0, 2'h0, 32'h11223344, 32'h0, 32'h0, 32'h0, 2, 2);
        chk("split long", {u_slave.mem[6], u_slave.mem[7], u_slave.mem[8], u_slave.mem[9]}, 32'h11223344);
        run(ABW_OP_WRITE, 32'h11, 32'h0, 2'h3, 32'hABCDEF, 32'h0, 32'h0, 32'h0, 1, 1);
        chk("three bytes", {8'h0, u_slave.mem[17], u_slave.mem[18], u_slave.mem[19]}, 32'hABCDEF);
    endtask
    task automatic t_locked;
        run(ABW_OP_CAS, 32'h30, 32'h0, 2'h0, 32'h77, 32'h0, 32'h0, 32'h0, 2, 1);
        chk("cas swap", {rsp_q.swapped, rsp_q.rdata[30:0]}, 32'h80000000);
        run(ABW_OP_CAS, 32'h30, 32'h0, 2'h0, 32'h99, 32'h0, 32'h5, 32'h0, 1, 0);
        chk("cas fail", {rsp_q.swapped, rsp_q.rdata[30:0]}, 32'h77);
        chk("cas kept", u_slave.mem[51], 32'h77);
        run(ABW_OP_TEST_SET, 32'h3C, 32'h0, 2'h1, 32'h0, 32'h0, 32'h0, 32'h0, 2, 1);
        chk("test and set", u_slave.mem[60], 32'h80);
        run(ABW_OP_DUAL_CAS, 32'h30, 32'h38, 2'h0, 32'h1, 32'h2, 32'h77, 32'h0, 4, 2);
        chk("dual cas", {u_slave.mem[51], u_slave.mem[59], 15'h0, rsp_q.swapped}, 32'h01020001);
    endtask
    task automatic t_grant;
        int t;
        chk("idle", {addr_strobe_n, data_strobe_n, locked_cycle_n, data_oe}, 32'hE);
        bus_request_n <= 1'b0;
        t = 0;
        do @(posedge clock); while (bus_grant_n !== 1'b0 && ++t < 5);
        chk("grant", bus_grant_n, 32'h0);
        bus_request_n <= 1'b1;
        repeat (3) @(posedge clock);
        chk("grant off", bus_grant_n, 32'h1);
        // A bus request in the middle of a locked operation waits for its end
        req_data <= '{op: ABW_OP_CAS, addr: 32'h30, space: 3'h5, cmp: 32'h5, default: '0};
        req_valid <= 1'b1;
        @(posedge clock);
        req_valid <= 1'b0;
        repeat (3) @(posedge clock);
        bus_request_n <= 1'b0;
        repeat (4) @(posedge clock);
        chk("grant in lock", {locked_cycle_n, bus_grant_n}, 32'h1);
        t = 0;
        do @(posedge clock); while (bus_grant_n !== 1'b0 && ++t < 20);
        chk("grant after lock", {locked_cycle_n, bus_grant_n}, 32'h2);
        bus_request_n <= 1'b1;
        repeat (3) @(posedge clock);
        chk("reduced strobes", r_seen, 32'h0);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        t_write_waits();
        t_misaligned();
        t_locked();
        t_grant();
        tally_and_finish();
    end
endmodule

// >>> src/abw_fifo.sv
// Request FIFO: flip-flop storage, valid/ready on both sides.
// Assumes DEPTH is a power of two; in_ready comes from a flop.
`timescale 1ns/1ps
module abw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_COUNT = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic full;
    wire push = in_valid && !full;
    wire pop = out_valid && out_ready;
    wire [PW:0] next_count = count + (PW+1)'(push) - (PW+1)'(pop);

    // Pointers, fill level and registered room flag, so ready leaves a flop
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            count <= next_count;
            in_ready <= (next_count != DEPTH_COUNT);
        end
    end

    // Entry storage, one flop row per entry
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clock) begin
            if (push && wr_ptr == PW'(i)) store[i] <= in_data;
        end
    end

    assign full = !in_ready;
    assign out_valid = (count != '0);
    assign out_data = store[rd_ptr];
endmodule

// >>> src/abw_pkg.sv
// Shared types and constants for the asynchronous bus write and locked
// read-modify-write sequencer.
// Assumes a single processor-side clock; bus inputs arrive synchronous to it.
package abw_pkg;

    // Operations that the core hands to the sequencer
    typedef enum logic [1:0] {
        ABW_OP_WRITE = 2'h0,
        ABW_OP_TEST_SET = 2'h1,
        ABW_OP_CAS = 2'h2,
        ABW_OP_DUAL_CAS = 2'h3
    } abw_op_type;

    // One request: a plain write or a locked operation
    typedef struct packed {
        abw_op_type op;
        logic [31:0] addr;
        logic [31:0] addr2;
        logic [2:0] space;
        logic [1:0] size;
        logic [31:0] wdata;
        logic [31:0] wdata2;
        logic [31:0] cmp;
        logic [31:0] cmp2;
    } abw_req_type;

    // Result of a locked operation
    typedef struct packed {
        logic swapped;
        logic [31:0] rdata;
        logic [31:0] rdata2;
    } abw_rsp_type;

    // Bus sequencer states, one-hot
    typedef enum logic [10:0] {
        ABW_ST_IDLE = 11'h001,
        ABW_ST_PREP = 11'h002,
        ABW_ST_S0 = 11'h004,
        ABW_ST_S1 = 11'h008,
        ABW_ST_S2 = 11'h010,
        ABW_ST_S3 = 11'h020,
        ABW_ST_SW1 = 11'h040,
        ABW_ST_SW2 = 11'h080,
        ABW_ST_S4 = 11'h100,
        ABW_ST_S5 = 11'h200,
        ABW_ST_MOD = 11'h400
    } abw_state_type;

    // Operand phases of one operation, one-hot
    typedef enum logic [3:0] {
        ABW_PH_RD1 = 4'h1,
        ABW_PH_RD2 = 4'h2,
        ABW_PH_WR1 = 4'h4,
        ABW_PH_WR2 = 4'h8
    } abw_phase_type;

    localparam int ABW_REQ_BITS = $bits(abw_req_type);
    localparam int ABW_FIFO_DEPTH = 4;
    localparam logic [31:0] ABW_ADDR_MASK_FULL = 32'hFFFFFFFF;
    localparam logic [31:0] ABW_ADDR_MASK_REDUCED = 32'h00FFFFFF;
    localparam logic [31:0] ABW_TEST_SET_BIT = 32'h00000080;
    localparam logic [2:0] ABW_PORT_32 = 3'h4;
    localparam logic [2:0] ABW_PORT_16 = 3'h2;
    localparam logic [2:0] ABW_PORT_8 = 3'h1;
    localparam logic [2:0] ABW_BYTES_LONG = 3'h4;
    localparam logic [1:0] ABW_SIZE_LONG = 2'h0;
    localparam logic [2:0] ABW_SPACE_RESET = 3'h0;

endpackage

// >>> src/abw_sequencer.sv
// Bus-master sequencer for write cycles and locked read-modify-write
// operations on a nonmultiplexed asynchronous address/data bus.
// Assumes one bus state per clock, slave inputs synchronous to clock.
//
// Overview of operation
// - S0 drives address, space, direction low, size
// - S0 pulses cycle start, operand start on first
// - Address strobe asserted from S1
// - Full variant enables data buffers in S1
// - Cycle and operand start negated in S1
// - Write data driven from S2
// - Acknowledges sampled at end of S2
// - Data strobe asserted from S3
// - Early acknowledge ends cycle without wait states
// - No acknowledge inserts waits, keep sampling
// - S4 changes no control signal
// - S5 negates strobes, holds address and data
// - S5 keeps direction, size, space, buffer enable
// - Lock held through whole locked sequence
// - No bus grant during locked sequence
// - Only locked ops; failed compare skips write
// - Reduced variant drives 24-bit address only
// - Reduced variant lacks start strobes, buffer enable
// - Read direction until write S0, data later
// - Lock asserted from first read S0
`timescale 1ns/1ps
module abw_sequencer #(
    parameter bit REDUCED = 1'b0
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire abw_pkg::abw_req_type req_data,
    output logic rsp_valid,
    output abw_pkg::abw_rsp_type rsp_data,
    output logic [31:0] addr,
    output logic [2:0] space_code,
    output logic read_write,
    output logic xfer_size_hi,
    output logic xfer_size_lo,
    output logic addr_strobe_n,
    output logic data_strobe_n,
    output logic data_buffer_enable_n,
    output logic ext_cycle_start_n,
    output logic operand_cycle_start_n,
    output logic locked_cycle_n,
    output logic [31:0] data_out,
    output logic data_oe,
    input wire logic [31:0] data_in,
    input wire logic xfer_ack_hi_n,
    input wire logic xfer_ack_lo_n,
    input wire logic bus_request_n,
    output logic bus_grant_n
);
    import abw_pkg::*;

    logic fifo_valid;
    logic fifo_ready;
    logic [ABW_REQ_BITS-1:0] fifo_bits;
    abw_req_type fifo_req;

    abw_fifo #(.WIDTH(ABW_REQ_BITS), .DEPTH(ABW_FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data(req_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_bits)
    );
    assign fifo_req = abw_req_type'(fifo_bits);

    abw_state_type state, next_state;
    abw_phase_type phase, next_phase;
    abw_req_type op_q, next_op;
    logic [31:0] cur_addr, next_addr;
    logic [2:0] rem, next_rem;
    logic [31:0] wbuf, next_wbuf;
    logic [31:0] acc, next_acc;
    logic [31:0] read1, next_read1;
    logic [2:0] port_q, next_port;
    logic ack_flag, next_ack_flag;
    logic first, next_first;
    logic rmw, next_rmw;
    logic next_rsp_valid;

    // Acknowledge decode and port width
    wire ack_seen = !xfer_ack_hi_n || !xfer_ack_lo_n;
    wire [2:0] port_now = (!xfer_ack_hi_n && !xfer_ack_lo_n) ? ABW_PORT_32 :
                          (!xfer_ack_hi_n) ? ABW_PORT_16 : ABW_PORT_8;

    // Bytes moved by this cycle: bounded by port room and what is left
    wire [1:0] port_off = cur_addr[1:0] & (port_q[1:0] - 2'h1);
    wire [2:0] port_room = port_q - {1'b0, port_off};
    wire [2:0] taken = (rem < port_room) ? rem : port_room;
    wire [5:0] taken_sh = {taken, 3'b000};
    wire [31:0] rd_shifted = data_in << {port_off, 3'b000};
    wire [5:0] keep_sh = {ABW_BYTES_LONG - taken, 3'b000};
    wire [31:0] rd_got = rd_shifted >> keep_sh;

    // Phase loading values
    wire second = (phase == ABW_PH_RD2) || (phase == ABW_PH_WR2);
    wire is_write_ph = (phase == ABW_PH_WR1) || (phase == ABW_PH_WR2);
    wire [2:0] op_bytes = (op_q.size == ABW_SIZE_LONG) ? ABW_BYTES_LONG : {1'b0, op_q.size};
    wire [31:0] wr_value = (phase == ABW_PH_WR2) ? op_q.wdata2 :
                           (op_q.op == ABW_OP_TEST_SET) ? (read1 | ABW_TEST_SET_BIT) : op_q.wdata;
    wire [5:0] just_sh = {ABW_BYTES_LONG - op_bytes, 3'b000};
    wire hit1 = (read1 == op_q.cmp);
    wire hit2 = (acc == op_q.cmp2);
    wire do_swap = (op_q.op == ABW_OP_TEST_SET) || ((op_q.op == ABW_OP_CAS) && hit1) ||
                   ((op_q.op == ABW_OP_DUAL_CAS) && hit1 && hit2);
    wire last_cycle = (rem == taken);
    assign fifo_ready = (state == ABW_ST_IDLE) && bus_request_n;

    // Next-state and datapath sequencing
    always_comb begin
        next_state = state;
        next_phase = phase;
        next_op = op_q;
        next_addr = cur_addr;
        next_rem = rem;
        next_wbuf = wbuf;
        next_acc = acc;
        next_read1 = read1;
        next_port = port_q;
        next_ack_flag = ack_flag;
        next_first = first;
        next_rmw = rmw;
        next_rsp_valid = 1'b0;
        case (state)
            ABW_ST_IDLE: begin
                // Another master asking for the bus holds us idle
                if (fifo_valid && bus_request_n) begin
                    next_op = fifo_req;
                    next_rmw = (fifo_req.op != ABW_OP_WRITE);
                    next_phase = (fifo_req.op == ABW_OP_WRITE) ? ABW_PH_WR1 : ABW_PH_RD1;
                    next_state = ABW_ST_PREP;
                end
            end
            ABW_ST_PREP: begin
                next_addr = second ? op_q.addr2 : op_q.addr;
                next_rem = op_bytes;
                next_wbuf = wr_value << just_sh; // Operand left-justified
                next_acc = '0;
                next_first = 1'b1;
                next_state = ABW_ST_S0;
            end
            ABW_ST_S0: next_state = ABW_ST_S1;
            ABW_ST_S1: next_state = ABW_ST_S2;
            ABW_ST_S2: begin
                next_ack_flag = ack_seen;
                if (ack_seen) next_port = port_now;
                next_state = ABW_ST_S3;
            end
            ABW_ST_S3: next_state = ack_flag ? ABW_ST_S4 : ABW_ST_SW1;
            ABW_ST_SW1: next_state = ABW_ST_SW2;
            ABW_ST_SW2: begin
                // Wait states resample on every falling-edge slot
                if (ack_seen) begin
                    next_port = port_now;
                    next_state = ABW_ST_S4;
                end else begin
                    next_state = ABW_ST_SW1;
                end
            end
            ABW_ST_S4: begin
                if (!is_write_ph) next_acc = (acc << taken_sh) | rd_got;
                next_state = ABW_ST_S5;
            end
            ABW_ST_S5: begin
                next_rem = rem - taken;
                next_addr = cur_addr + {29'h0, taken};
                next_wbuf = wbuf << taken_sh;
                next_first = 1'b0;
                next_ack_flag = 1'b0;
                if (!last_cycle) begin
                    next_state = ABW_ST_S0;
                end else begin
                    case (phase)
                        ABW_PH_RD1: begin
                            next_read1 = acc;
                            next_phase = ABW_PH_RD2;
                            next_state = (op_q.op == ABW_OP_DUAL_CAS) ? ABW_ST_PREP : ABW_ST_MOD;
                        end
                        ABW_PH_RD2: next_state = ABW_ST_MOD;
                        ABW_PH_WR1: begin
                            next_phase = ABW_PH_WR2;
                            next_state = (op_q.op == ABW_OP_DUAL_CAS) ? ABW_ST_PREP : ABW_ST_IDLE;
                        end
                        default: next_state = ABW_ST_IDLE;
                    endcase
                    if (next_state == ABW_ST_IDLE) next_rmw = 1'b0;
                end
            end
            ABW_ST_MOD: begin
                next_rsp_valid = 1'b1;
                next_phase = ABW_PH_WR1;
                if (do_swap) begin
                    next_state = ABW_ST_PREP;
                end else begin
                    next_state = ABW_ST_IDLE;
                    next_rmw = 1'b0;
                end
            end
            default: next_state = ABW_ST_IDLE;
        endcase
    end

    // Output decode from the coming state
    wire n_cycle = (next_state == ABW_ST_S0) || (next_state == ABW_ST_S1) || (next_state == ABW_ST_S2) ||
                   (next_state == ABW_ST_S3) || (next_state == ABW_ST_SW1) || (next_state == ABW_ST_SW2) ||
                   (next_state == ABW_ST_S4) || (next_state == ABW_ST_S5);
    wire n_wr = n_cycle && ((next_phase == ABW_PH_WR1) || (next_phase == ABW_PH_WR2));
    wire n_mid = (next_state == ABW_ST_S3) || (next_state == ABW_ST_SW1) ||
                 (next_state == ABW_ST_SW2) || (next_state == ABW_ST_S4);
    wire n_as = n_mid || (next_state == ABW_ST_S1) || (next_state == ABW_ST_S2);
    wire n_dstb = n_wr ? n_mid : n_as;
    wire n_bufen = n_wr ? (n_as || (next_state == ABW_ST_S5)) : (n_mid || (next_state == ABW_ST_S2));
    wire n_data = n_wr && (n_mid || (next_state == ABW_ST_S2) || (next_state == ABW_ST_S5));
    wire n_s0 = (next_state == ABW_ST_S0);
    wire [31:0] addr_mask = REDUCED ? ABW_ADDR_MASK_REDUCED : ABW_ADDR_MASK_FULL;
    wire [31:0] lane_data = next_wbuf >> {next_addr[1:0], 3'b000};

    // Sequencer registers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state <= ABW_ST_IDLE;
            phase <= ABW_PH_WR1;
            op_q <= '0;
            cur_addr <= '0;
            rem <= '0;
            wbuf <= '0;
            acc <= '0;
            read1 <= '0;
            port_q <= ABW_PORT_32;
            ack_flag <= 1'b0;
            first <= 1'b0;
            rmw <= 1'b0;
        end else begin
            state <= next_state;
            phase <= next_phase;
            op_q <= next_op;
            cur_addr <= next_addr;
            rem <= next_rem;
            wbuf <= next_wbuf;
            acc <= next_acc;
            read1 <= next_read1;
            port_q <= next_port;
            ack_flag <= next_ack_flag;
            first <= next_first;
            rmw <= next_rmw;
        end
    end

    // Bus strobes; S4 and S5 keep what S3 set apart from the negations
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            addr_strobe_n <= 1'b1;
            data_strobe_n <= 1'b1;
            data_buffer_enable_n <= 1'b1;
            ext_cycle_start_n <= 1'b1;
            operand_cycle_start_n <= 1'b1;
            locked_cycle_n <= 1'b1;
            data_oe <= 1'b0;
            read_write <= 1'b1;
            bus_grant_n <= 1'b1;
        end else begin
            addr_strobe_n <= !n_as;
            data_strobe_n <= !n_dstb;
            data_buffer_enable_n <= REDUCED || !n_bufen;
            ext_cycle_start_n <= REDUCED || !n_s0;
            operand_cycle_start_n <= REDUCED || !(n_s0 && next_first);
            locked_cycle_n <= !(next_rmw && (n_s0 || !locked_cycle_n)); // Lock starts at read S0
            data_oe <= n_data;
            read_write <= !n_wr;
            bus_grant_n <= !(!bus_request_n && !next_rmw && next_state == ABW_ST_IDLE);
        end
    end

    // Address, space, size and data: loaded at cycle start, held otherwise
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            addr <= '0;
            space_code <= ABW_SPACE_RESET;
            xfer_size_hi <= 1'b0;
            xfer_size_lo <= 1'b0;
            data_out <= '0;
        end else if (n_s0) begin
            addr <= next_addr & addr_mask;
            space_code <= next_op.space;
            xfer_size_hi <= next_rem[1];
            xfer_size_lo <= next_rem[0];
            data_out <= lane_data;
        end
    end

    // Locked-operation result
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_data <= '0;
        end else begin
            rsp_valid <= next_rsp_valid;
            if (next_rsp_valid) begin
                rsp_data.swapped <= do_swap;
                rsp_data.rdata <= read1;
                rsp_data.rdata2 <= acc;
            end
        end
    end
endmodule
